// ### hw/interval_timer.sv
// Purpose: three channel programmable interval timer behind host i/o ports
// Assumes: host read and write strobes last one core clock each
// Notes: direct unlatched reads of a running count may tear between bytes
`timescale 1ns/1ns
`default_nettype none
module interval_timer (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_osc14_clk,
  input wire logic [7:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_tod_irq,
  output logic o_refresh_req,
  output logic o_speaker,
  output logic o_ch2_output_flag
);

  timer_tick_if tk ();

  timer_tick_gen u_tick (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_osc14_clk(i_osc14_clk),
    .tk(tk)
  );

  // bcd or binary decrement, wrapping below zero
  function automatic logic [15:0] cnt_dec(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - 16'h0001;
    end else begin
      for (int d = 0; d < 4; d++) begin
        if (borrow) begin
          if (v[4*d +: 4] == 4'h0) begin
            r[4*d +: 4] = 4'h9;
          end else begin
            r[4*d +: 4] = v[4*d +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction : cnt_dec

  // binary magnitude of a count, zero standing for full range
  function automatic logic [16:0] cnt_val(input logic [15:0] v, input logic bcd);
    logic [16:0] r;
    r = {1'b0, v};
    if (v == 16'h0000) begin
      r = bcd ? interval_timer_pkg::BCD_FULL : interval_timer_pkg::BIN_FULL;
    end else if (bcd) begin
      r = 17'(v[15:12]) * 17'd1000 + 17'(v[11:8]) * 17'd100
          + 17'(v[7:4]) * 17'd10 + 17'(v[3:0]);
    end
    return r;
  endfunction : cnt_val

  // bit 3 is a don't-care for modes 2 and 3
  function automatic interval_timer_pkg::mode_e mode_dec(input logic [2:0] m);
    return interval_timer_pkg::mode_e'(m[1] ? {1'b0, m[1:0]} : m);
  endfunction : mode_dec

  logic [15:0] count_r [3];
  logic [15:0] cr_r [3];
  logic [15:0] latch_r [3];
  logic [16:0] n_r [3];
  logic [5:0] ctrl_r [3];
  logic [7:0] status_r [3];
  logic [2:0] out_r;
  logic [2:0] null_r;
  logic [2:0] loadreq_r;
  logic [2:0] started_r;
  logic [2:0] armed_r;
  logic [2:0] trig_r;
  logic [2:0] gate_q_r;
  logic [2:0] latched_r;
  logic [2:0] stat_valid_r;
  logic [2:0] wr_hi_r;
  logic [2:0] rd_hi_r;
  logic gate_bit_r;
  logic [7:0] rdata_r;

  logic [2:0] gate;
  logic [2:0] chan_hit;
  logic cw_wr;
  logic rb_cmd;
  logic [1:0] cw_sel;
  logic [1:0] cw_rw;
  logic [15:0] dec_w [3];
  logic [7:0] rd_byte [3];
  interval_timer_pkg::mode_e mode_w [3];

  assign gate = {gate_bit_r, 1'b1, 1'b1};
  assign cw_sel = i_io_wdata[interval_timer_pkg::CW_SEL_LSB +: 2];
  assign cw_rw = i_io_wdata[interval_timer_pkg::CW_RW_LSB +: 2];
  assign cw_wr = i_io_wr && (i_io_addr == interval_timer_pkg::ADDR_CTRL);
  assign rb_cmd = cw_wr && (cw_sel == interval_timer_pkg::SEL_READBACK);

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      chan_hit[i] = ((i_io_addr & interval_timer_pkg::ADDR_TIMER_MASK)
                    == interval_timer_pkg::ADDR_CNT0) && (i_io_addr[1:0] == 2'(i));
      mode_w[i] = mode_dec(ctrl_r[i][interval_timer_pkg::CW_MODE_LSB +: 3]);
      dec_w[i] = cnt_dec(count_r[i], ctrl_r[i][interval_timer_pkg::CW_BCD_BIT]);
      rd_byte[i] = 8'h00;
      if (stat_valid_r[i]) begin
        rd_byte[i] = status_r[i];
      end else begin
        case (ctrl_r[i][interval_timer_pkg::CW_RW_LSB +: 2])
          interval_timer_pkg::RW_LOW: rd_byte[i] = latched_r[i] ? latch_r[i][7:0] : count_r[i][7:0];
          interval_timer_pkg::RW_HIGH: rd_byte[i] = latched_r[i] ? latch_r[i][15:8] : count_r[i][15:8];
          interval_timer_pkg::RW_WORD: begin
            if (rd_hi_r[i]) begin
              rd_byte[i] = latched_r[i] ? latch_r[i][15:8] : count_r[i][15:8];
            end else begin
              rd_byte[i] = latched_r[i] ? latch_r[i][7:0] : count_r[i][7:0];
            end
          end
          default: rd_byte[i] = 8'h00;
        endcase
      end
    end
  end

  // port b gate control
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gate_bit_r <= interval_timer_pkg::PORTB_GATE_RST;
    end else if (i_io_wr && (i_io_addr == interval_timer_pkg::ADDR_PORTB)) begin
      gate_bit_r <= i_io_wdata[interval_timer_pkg::PORTB_GATE_BIT];
    end
  end

  // read data path; unmapped addresses read zero
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_r <= interval_timer_pkg::RDATA_RST;
    end else if (i_io_rd) begin
      rdata_r <= 8'h00;
      if (i_io_addr == interval_timer_pkg::ADDR_PORTB) begin
        rdata_r[interval_timer_pkg::PORTB_GATE_BIT] <= gate_bit_r;
        rdata_r[interval_timer_pkg::PORTB_CH2_OUTPUT_FLAG_BIT] <= out_r[2];
      end else begin
        for (int i = 0; i < 3; i++) begin
          if (chan_hit[i]) begin
            rdata_r <= rd_byte[i];
          end
        end
      end
    end
  end

  // counter cores and their host-side state
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < 3; i++) begin
        count_r[i] <= interval_timer_pkg::COUNT_RST;
        cr_r[i] <= interval_timer_pkg::COUNT_RST;
        latch_r[i] <= interval_timer_pkg::COUNT_RST;
        n_r[i] <= interval_timer_pkg::BIN_FULL;
        ctrl_r[i] <= interval_timer_pkg::CTRL_RST;
        status_r[i] <= 8'h00;
      end
      out_r <= 3'b000;
      null_r <= 3'b000;
      loadreq_r <= 3'b000;
      started_r <= 3'b000;
      armed_r <= 3'b000;
      trig_r <= 3'b000;
      gate_q_r <= 3'b000;
      latched_r <= 3'b000;
      stat_valid_r <= 3'b000;
      wr_hi_r <= 3'b000;
      rd_hi_r <= 3'b000;
    end else begin
      gate_q_r <= gate;
      for (int i = 0; i < 3; i++) begin
        // a gate rise held until the next tick; a new rise wins over the clear
        trig_r[i] <= (gate[i] && !gate_q_r[i]) || (trig_r[i] && !tk.tick);
        if (tk.tick) begin
          if (trig_r[i] && (mode_w[i] == interval_timer_pkg::MODE1
              || mode_w[i] == interval_timer_pkg::MODE2
              || mode_w[i] == interval_timer_pkg::MODE3
              || mode_w[i] == interval_timer_pkg::MODE5)) begin
            count_r[i] <= cr_r[i];
            n_r[i] <= cnt_val(cr_r[i], ctrl_r[i][interval_timer_pkg::CW_BCD_BIT]);
            null_r[i] <= 1'b0;
            started_r[i] <= 1'b1;
            armed_r[i] <= 1'b1;
            loadreq_r[i] <= 1'b0;
            out_r[i] <= (mode_w[i] != interval_timer_pkg::MODE1);
          end else if (loadreq_r[i]) begin
            count_r[i] <= cr_r[i];
            n_r[i] <= cnt_val(cr_r[i], ctrl_r[i][interval_timer_pkg::CW_BCD_BIT]);
            null_r[i] <= 1'b0;
            started_r[i] <= 1'b1;
            armed_r[i] <= 1'b1;
            loadreq_r[i] <= 1'b0;
            out_r[i] <= (mode_w[i] != interval_timer_pkg::MODE0);
          end else if (started_r[i] && (gate[i] || mode_w[i] == interval_timer_pkg::MODE1)) begin
            case (mode_w[i])
              interval_timer_pkg::MODE0, interval_timer_pkg::MODE1: begin
                count_r[i] <= dec_w[i];
                if (dec_w[i] == 16'h0000) begin
                  out_r[i] <= 1'b1;
                end
              end
              interval_timer_pkg::MODE2, interval_timer_pkg::MODE3: begin
                if (count_r[i] == 16'h0001) begin
                  count_r[i] <= cr_r[i];
                  n_r[i] <= cnt_val(cr_r[i], ctrl_r[i][interval_timer_pkg::CW_BCD_BIT]);
                  null_r[i] <= 1'b0;
                  out_r[i] <= 1'b1;
                end else begin
                  count_r[i] <= dec_w[i];
                  if (mode_w[i] == interval_timer_pkg::MODE2) begin
                    out_r[i] <= (dec_w[i] != 16'h0001);
                  end else begin
                    // high while more than half remains, so odd counts stay high longer
                    out_r[i] <= cnt_val(dec_w[i], ctrl_r[i][interval_timer_pkg::CW_BCD_BIT])
                                > (n_r[i] >> 1);
                  end
                end
              end
              interval_timer_pkg::MODE4, interval_timer_pkg::MODE5: begin
                if (mode_w[i] == interval_timer_pkg::MODE5 && count_r[i] == 16'h0000
                    && null_r[i]) begin
                  count_r[i] <= cr_r[i];
                  n_r[i] <= cnt_val(cr_r[i], ctrl_r[i][interval_timer_pkg::CW_BCD_BIT]);
                  null_r[i] <= 1'b0;
                  armed_r[i] <= 1'b1;
                  out_r[i] <= 1'b1;
                end else begin
                  // one strobe per load, not one per wrap
                  count_r[i] <= dec_w[i];
                  out_r[i] <= !(dec_w[i] == 16'h0000 && armed_r[i]);
                  if (dec_w[i] == 16'h0000) begin
                    armed_r[i] <= 1'b0;
                  end
                end
              end
              default: count_r[i] <= count_r[i];
            endcase
          end
        end
        if (mode_w[i] == interval_timer_pkg::MODE3 && !gate[i]) begin
          out_r[i] <= 1'b1;
        end

        // host writes come last so a write wins over a same-cycle load
        if (cw_wr && !rb_cmd && cw_sel == 2'(i)) begin
          if (cw_rw == interval_timer_pkg::RW_LATCH) begin
            if (!latched_r[i]) begin
              latch_r[i] <= count_r[i];
              latched_r[i] <= 1'b1;
            end
          end else begin
            ctrl_r[i] <= i_io_wdata[5:0];
            out_r[i] <= (mode_dec(i_io_wdata[3:1]) != interval_timer_pkg::MODE0);
            started_r[i] <= 1'b0;
            loadreq_r[i] <= 1'b0;
            null_r[i] <= 1'b1;
            wr_hi_r[i] <= 1'b0;
            rd_hi_r[i] <= 1'b0;
            latched_r[i] <= 1'b0;
            stat_valid_r[i] <= 1'b0;
          end
        end
        if (rb_cmd && i_io_wdata[interval_timer_pkg::RB_SEL_LSB + i]) begin
          if (!i_io_wdata[interval_timer_pkg::RB_COUNT_N_BIT] && !latched_r[i]) begin
            latch_r[i] <= count_r[i];
            latched_r[i] <= 1'b1;
          end
          if (!i_io_wdata[interval_timer_pkg::RB_STATUS_N_BIT] && !stat_valid_r[i]) begin
            status_r[i] <= {out_r[i], null_r[i], ctrl_r[i]};
            stat_valid_r[i] <= 1'b1;
          end
        end
        if (i_io_wr && chan_hit[i]) begin
          case (ctrl_r[i][interval_timer_pkg::CW_RW_LSB +: 2])
            interval_timer_pkg::RW_LOW: cr_r[i] <= {8'h00, i_io_wdata};
            interval_timer_pkg::RW_HIGH: cr_r[i] <= {i_io_wdata, 8'h00};
            interval_timer_pkg::RW_WORD: begin
              if (wr_hi_r[i]) begin
                cr_r[i][15:8] <= i_io_wdata;
              end else begin
                cr_r[i][7:0] <= i_io_wdata;
              end
              wr_hi_r[i] <= !wr_hi_r[i];
            end
            default: cr_r[i] <= cr_r[i];
          endcase
          if (ctrl_r[i][interval_timer_pkg::CW_RW_LSB +: 2] != interval_timer_pkg::RW_WORD
              || wr_hi_r[i]) begin
            null_r[i] <= 1'b1;
            if (mode_w[i] == interval_timer_pkg::MODE0 || mode_w[i] == interval_timer_pkg::MODE4
                || (!started_r[i] && (mode_w[i] == interval_timer_pkg::MODE2
                || mode_w[i] == interval_timer_pkg::MODE3))) begin
              loadreq_r[i] <= 1'b1;
            end
          end
        end
        if (i_io_rd && chan_hit[i]) begin
          if (stat_valid_r[i]) begin
            stat_valid_r[i] <= 1'b0;
          end else if (ctrl_r[i][interval_timer_pkg::CW_RW_LSB +: 2]
                       == interval_timer_pkg::RW_WORD) begin
            rd_hi_r[i] <= !rd_hi_r[i];
            if (rd_hi_r[i]) begin
              latched_r[i] <= 1'b0;
            end
          end else begin
            latched_r[i] <= 1'b0;
          end
        end
      end
    end
  end

  assign o_io_rdata = rdata_r;
  assign o_tod_irq = out_r[0];
  assign o_refresh_req = out_r[1];
  assign o_speaker = out_r[2];
  assign o_ch2_output_flag = out_r[2];

endmodule : interval_timer
`default_nettype wire

// ### hw/interval_timer_pkg.sv
// Purpose: shared constants and types for the three channel interval timer
// Assumes: host port strobes are one core clock wide and synchronous
// Notes: port offsets are the host i/o byte addresses
package interval_timer_pkg;

  // host i/o port map
  localparam logic [7:0] ADDR_CNT0 = 8'h40;
  localparam logic [7:0] ADDR_CNT1 = 8'h41;
  localparam logic [7:0] ADDR_CNT2 = 8'h42;
  localparam logic [7:0] ADDR_CTRL = 8'h43;
  localparam logic [7:0] ADDR_PORTB = 8'h61;
  localparam logic [7:0] ADDR_TIMER_MASK = 8'hfc;

  // port b fields
  localparam int PORTB_GATE_BIT = 0;
  localparam int PORTB_CH2_OUTPUT_FLAG_BIT = 5;
  localparam logic PORTB_GATE_RST = 1'b0;

  // control word fields
  localparam int CW_BCD_BIT = 0;
  localparam int CW_MODE_LSB = 1;
  localparam int CW_RW_LSB = 4;
  localparam int CW_SEL_LSB = 6;
  localparam logic [1:0] SEL_READBACK = 2'b11;
  localparam logic [1:0] RW_LATCH = 2'b00;
  localparam logic [1:0] RW_LOW = 2'b01;
  localparam logic [1:0] RW_HIGH = 2'b10;
  localparam logic [1:0] RW_WORD = 2'b11;

  // read-back command fields
  localparam int RB_SEL_LSB = 1;
  localparam int RB_STATUS_N_BIT = 4;
  localparam int RB_COUNT_N_BIT = 5;

  // status byte fields
  localparam int ST_NULL_BIT = 6;
  localparam int ST_OUT_BIT = 7;

  // reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // full range of a zero count
  localparam logic [16:0] BIN_FULL = 17'h10000;
  localparam logic [16:0] BCD_FULL = 17'h02710;

  // tick derivation from the oscillator input
  localparam int OSC_KHZ = 14318;
  localparam int TICK_KHZ = 1190;
  localparam int TICK_DIV = OSC_KHZ / TICK_KHZ;
  localparam int CORE_MHZ = 50;

  typedef enum logic [2:0] {
    MODE0 = 3'b000,
    MODE1 = 3'b001,
    MODE2 = 3'b010,
    MODE3 = 3'b011,
    MODE4 = 3'b100,
    MODE5 = 3'b101
  } mode_e;

endpackage : interval_timer_pkg

// ### hw/timer_tick_gen.sv
// Purpose: divides the oscillator input down to the counter tick
// Assumes: oscillator input is sampled by the faster core clock
// Notes: core clock must exceed twice the oscillator rate
`timescale 1ns/1ns
`default_nettype none
module timer_tick_gen (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_osc14_clk,
  timer_tick_if.src tk
);
  localparam logic [3:0] DIV_LAST = 4'(interval_timer_pkg::TICK_DIV - 1);

  logic osc_q_r;
  logic [3:0] div_r;
  logic tick_r;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      osc_q_r <= 1'b0;
    end else begin
      osc_q_r <= i_osc14_clk;
    end
  end

  // one tick per twelve oscillator rising edges
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_r <= 4'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (i_osc14_clk && !osc_q_r) begin
        if (div_r == DIV_LAST) begin
          div_r <= 4'h0;
          tick_r <= 1'b1;
        end else begin
          div_r <= div_r + 4'h1;
        end
      end
    end
  end

  assign tk.tick = tick_r;
endmodule : timer_tick_gen
`default_nettype wire

// ### hw/timer_tick_if.sv
// Purpose: carries the common counter tick between timer modules
// Assumes: single core clock domain
// Notes: tick is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
interface timer_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : timer_tick_if
`default_nettype wire

// ### verification/host_io_model.sv
// Purpose: host processor model issuing i/o port cycles
// Assumes: one-cycle strobes launched just after a core clock edge
// Notes: released lines show inverted values so stale data cannot pass
`timescale 1ns/1ns
`default_nettype none
module host_io_model (
  input wire logic i_core_clk,
  output logic [7:0] o_io_addr,
  output logic o_io_wr,
  output logic o_io_rd,
  output logic [7:0] o_io_wdata
);
  initial begin
    o_io_addr = 8'h00;
    o_io_wr = 1'b0;
    o_io_rd = 1'b0;
    o_io_wdata = 8'h00;
  end
  task automatic access(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    #1;
    o_io_addr = a;
    o_io_wdata = is_wr ? d : ~o_io_wdata;
    o_io_wr = is_wr;
    o_io_rd = !is_wr;
    @(posedge i_core_clk);
    #1;
    o_io_wr = 1'b0;
    o_io_rd = 1'b0;
    o_io_addr = ~a;
    o_io_wdata = ~o_io_wdata;
  endtask : access
  // control word always goes ahead of the count bytes
  task automatic load(input logic [7:0] a, input logic [7:0] ctrl, input logic [15:0] cnt);
    access(1'b1, interval_timer_pkg::ADDR_CTRL, ctrl);
    access(1'b1, a, cnt[7:0]);
    access(1'b1, a, cnt[15:8]);
  endtask : load
endmodule : host_io_model
`default_nettype wire

// ### verification/interval_timer_sva.sv
// Purpose: port-level assertions for the interval timer
// Assumes: one core clock, async active-low reset
// Notes: attached by bind from the testbench top file
`timescale 1ns/1ns
`default_nettype none
module interval_timer_sva (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  input wire logic [7:0] o_io_rdata,
  input wire logic o_tod_irq,
  input wire logic o_refresh_req,
  input wire logic o_speaker,
  input wire logic o_ch2_output_flag
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // non-latch control word aimed at one counter
  sequence s_cfg(logic [1:0] sel);
    i_io_wr && i_io_addr == interval_timer_pkg::ADDR_CTRL && i_io_wdata[7:6] == sel
      && i_io_wdata[5:4] != 2'b00;
  endsequence
  sequence s_rd(logic [7:0] a);
    i_io_rd && i_io_addr == a;
  endsequence
  property p_rdata_hold;
    !i_io_rd |=> $stable(o_io_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
  property p_ctrl_rd_zero;
    s_rd(interval_timer_pkg::ADDR_CTRL) |=> o_io_rdata == 8'h00;
  endproperty
  a_ctrl_rd_zero: assert property (p_ctrl_rd_zero) else $error("control port read not zero");
  property p_unmapped_rd;
    i_io_rd && (i_io_addr & interval_timer_pkg::ADDR_TIMER_MASK) != interval_timer_pkg::ADDR_CNT0
      && i_io_addr != interval_timer_pkg::ADDR_PORTB |=> o_io_rdata == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
  property p_portb_rd;
    s_rd(interval_timer_pkg::ADDR_PORTB) |=> o_io_rdata[5] == $past(o_speaker)
      && {o_io_rdata[7:6], o_io_rdata[4:1]} == 6'h00;
  endproperty
  a_portb_rd: assert property (p_portb_rd) else $error("port b read wrong");
  property p_flag_same;
    o_ch2_output_flag == o_speaker;
  endproperty
  a_flag_same: assert property (p_flag_same) else $error("port b flag differs from speaker");
  property p_cfg_out0;
    s_cfg(2'b00) |=> o_tod_irq == ($past(i_io_wdata[3:1]) != 3'b000);
  endproperty
  a_cfg_out0: assert property (p_cfg_out0) else $error("counter 0 level after config");
  property p_cfg_out1;
    s_cfg(2'b01) |=> o_refresh_req == ($past(i_io_wdata[3:1]) != 3'b000);
  endproperty
  a_cfg_out1: assert property (p_cfg_out1) else $error("counter 1 level after config");
  property p_cfg_ch2_output_flag;
    s_cfg(2'b10) |=> o_speaker == ($past(i_io_wdata[3:1]) != 3'b000);
  endproperty
  a_cfg_ch2_output_flag: assert property (p_cfg_ch2_output_flag) else $error("counter 2 level after config");
endmodule : interval_timer_sva
`default_nettype wire

// ### verification/three_channel_interval_timer_tb.sv
// Purpose: self-checking bench for the interval timer
// Assumes: tick is 12 oscillator periods, 42 core cycles
// Notes: pulse widths allow two cycles of sync slack
`timescale 1ns/1ns
`default_nettype none
module three_channel_interval_timer_tb;
  typedef struct packed {logic [7:0] exp; logic [7:0] mask;} note_s;
  logic i_core_clk, i_resetn, i_osc14_clk, io_wr, io_rd;
  logic [7:0] io_addr, io_wdata, o_io_rdata;
  logic o_tod_irq, o_refresh_req, o_speaker, o_ch2_output_flag;
  note_s notes_q[$];
  note_s top_n;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] rng = 32'd98;
  logic pend = 1'b0;
  logic [7:0] tab_ctrl [7] = '{8'h34, 8'h3c, 8'h76, 8'h7e, 8'hb2, 8'hba, 8'hb8};
  int tab_cnt [7] = '{4, 4, 5, 5, 3, 3, 3};
  int tab_low [7] = '{1, 1, 2, 2, 3, 1, 1};
  host_io_model host (.i_core_clk(i_core_clk), .o_io_addr(io_addr), .o_io_wr(io_wr),
    .o_io_rd(io_rd), .o_io_wdata(io_wdata));
  interval_timer dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_osc14_clk(i_osc14_clk),
    .i_io_addr(io_addr), .i_io_wr(io_wr), .i_io_rd(io_rd), .i_io_wdata(io_wdata),
    .o_io_rdata(o_io_rdata), .o_tod_irq(o_tod_irq), .o_refresh_req(o_refresh_req),
    .o_speaker(o_speaker), .o_ch2_output_flag(o_ch2_output_flag));
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  initial begin
    i_osc14_clk = 1'b0;
    forever #35 i_osc14_clk = ~i_osc14_clk;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  function automatic logic pick(input int ch);
    return ch == 0 ? o_tod_irq : (ch == 1 ? o_refresh_req : o_speaker);
  endfunction : pick
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d);
  endtask : wr
  // the note is queued before the strobe so the monitor always finds it
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
    notes_q.push_back('{exp, mask});
    host.access(1'b0, a, 8'h00);
  endtask : rd
  task automatic wait_lvl(input int ch, input logic lvl, output int n);
    n = 0;
    while (pick(ch) !== lvl && n < 2000) begin
      @(posedge i_core_clk);
      #2;
      n++;
    end
  endtask : wait_lvl
  always @(negedge i_core_clk) begin
    if (pend && notes_q.size() > 0) begin
      top_n = notes_q.pop_front();
      check({8'h00, o_io_rdata & top_n.mask}, {8'h00, top_n.exp & top_n.mask});
    end
    pend = io_rd;
  end
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    logic [7:0] a;
    logic [15:0] n16;
    int n;
    int ch;
    i_resetn = 1'b0;
    repeat (20) @(posedge i_core_clk);
    #1 i_resetn = 1'b1;
    rd(interval_timer_pkg::ADDR_PORTB, 8'h00, 8'hff);
    rd(interval_timer_pkg::ADDR_CTRL, 8'h00, 8'hff);
    repeat (4) begin
      rng = xorshift(rng);
      a = rng[7:0];
      if ((a & 8'hfc) != 8'h40 && a != 8'h61) rd(a, 8'h00, 8'hff);
    end
    // counter 2 held by its gate so latched values are exact
    wr(interval_timer_pkg::ADDR_CTRL, 8'hb0);
    wr(interval_timer_pkg::ADDR_CTRL, 8'he8);
    rd(interval_timer_pkg::ADDR_CNT2, 8'h70, 8'hff);
    rng = xorshift(rng);
    n16 = rng[15:0];
    wr(interval_timer_pkg::ADDR_CNT2, n16[7:0]);
    wr(interval_timer_pkg::ADDR_CNT2, n16[15:8]);
    repeat (100) @(posedge i_core_clk);
    wr(interval_timer_pkg::ADDR_CTRL, 8'hc8);
    wr(interval_timer_pkg::ADDR_PORTB, 8'h01);
    repeat (200) @(posedge i_core_clk);
    rd(interval_timer_pkg::ADDR_CNT2, 8'h30, 8'hff);
    rd(interval_timer_pkg::ADDR_CNT2, n16[7:0], 8'hff);
    rd(interval_timer_pkg::ADDR_CNT2, n16[15:8], 8'hff);
    wr(interval_timer_pkg::ADDR_PORTB, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(interval_timer_pkg::ADDR_CTRL, i ? 8'ha0 : 8'h90);
      wr(interval_timer_pkg::ADDR_CNT2, i ? 8'h12 : 8'h07);
      repeat (100) @(posedge i_core_clk);
      wr(interval_timer_pkg::ADDR_CTRL, 8'h80);
      rd(interval_timer_pkg::ADDR_CNT2, i ? 8'h12 : 8'h07, 8'hff);
    end
    host.load(interval_timer_pkg::ADDR_CNT2, 8'hb0, 16'h0003);
    wr(interval_timer_pkg::ADDR_PORTB, 8'h01);
    wait_lvl(2, 1'b1, n);
    check(16'(n >= 84 && n <= 252), 16'h0001);
    repeat (200) @(posedge i_core_clk);
    check(16'(o_speaker), 16'h0001);
    rd(interval_timer_pkg::ADDR_PORTB, 8'h21, 8'hff);
    // zero count must wrap to the top of each number system
    for (int b = 0; b < 2; b++) begin
      host.load(interval_timer_pkg::ADDR_CNT2, 8'hb0 | 8'(b), 16'h0000);
      repeat (200) @(posedge i_core_clk);
      wr(interval_timer_pkg::ADDR_CTRL, 8'h80);
      rd(interval_timer_pkg::ADDR_CNT2, 8'h00, 8'h00);
      rd(interval_timer_pkg::ADDR_CNT2, b ? 8'h99 : 8'hff, 8'hff);
    end
    for (int i = 0; i < 7; i++) begin
      ch = int'(tab_ctrl[i][7:6]);
      wr(interval_timer_pkg::ADDR_PORTB, 8'h00);
      host.load(interval_timer_pkg::ADDR_CNT0 + 8'(ch), tab_ctrl[i], 16'(tab_cnt[i]));
      wr(interval_timer_pkg::ADDR_PORTB, 8'h01);
      wait_lvl(ch, 1'b0, n);
      wait_lvl(ch, 1'b1, n);
      check(16'(n >= tab_low[i] * 42 - 2 && n <= tab_low[i] * 42 + 2), 16'h0001);
    end
    close_out();
  end
endmodule : three_channel_interval_timer_tb
bind interval_timer interval_timer_sva chk (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
  .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
  .o_io_rdata(o_io_rdata), .o_tod_irq(o_tod_irq), .o_refresh_req(o_refresh_req),
  .o_speaker(o_speaker), .o_ch2_output_flag(o_ch2_output_flag));
`default_nettype wire
